// >>> logic/udlc_defines.svh
// register offsets, field positions, reset values for device level control
`ifndef UDLC_DEFINES_SVH
`define UDLC_DEFINES_SVH
`define UDLC_OFF_ADDR 8'h00
`define UDLC_OFF_PWR 8'h01
`define UDLC_OFF_IN_FLAGS 8'h02
`define UDLC_OFF_OUT_FLAGS 8'h04
`define UDLC_OFF_CM_FLAGS 8'h06
`define UDLC_OFF_IN_EN 8'h07
`define UDLC_OFF_OUT_EN 8'h09
`define UDLC_OFF_CM_EN 8'h0b
`define UDLC_OFF_EP_SEL 8'h0e
`define UDLC_OFF_EP_CSR0 8'h11
`define UDLC_EP_CSR_NUM 5
`define UDLC_ADDR_PEND_BIT 7
`define UDLC_PWR_ISO_BIT 7
`define UDLC_PWR_INH_BIT 4
`define UDLC_PWR_BRST_BIT 3
`define UDLC_PWR_RWU_BIT 2
`define UDLC_PWR_SUSP_BIT 1
`define UDLC_PWR_SUSPEND_DETECT_ENABLE_BIT 0
`define UDLC_CM_SUSP_BIT 0
`define UDLC_CM_RESM_BIT 1
`define UDLC_CM_BRST_BIT 2
`define UDLC_CM_SOF_BIT 3
`define UDLC_CM_EN_RST 8'h06
`define UDLC_CM_EN_ON_BRST 8'h0e
`define UDLC_EP_EN_RST 8'h0f
`define UDLC_EP_EN_ON_BRST 8'h0f
`define UDLC_CM_MASK 8'h0f
`endif

// >>> logic/udlc_pkg.sv
// types shared by the device level control block
package udlc_pkg;
  typedef enum logic [2:0] {
    UDLC_ST_INHIBIT = 3'b001,
    UDLC_ST_ACTIVE = 3'b010,
    UDLC_ST_SUSPEND = 3'b100
  } udlc_state_t;

  // one-cycle events from the serial engine, same clock
  typedef struct packed {
    logic bus_reset;
    logic suspend;
    logic resume;
    logic sof;
    logic xfer_done;
    logic iso_load;
    logic iso_in_token;
  } udlc_evt_t;
endpackage

// >>> logic/udlc_top.sv
// device level control: address, reset, suspend, wakeup, iso sync, enable
//
// Contract
// [R1] seven-bit writable function address in low bits
// [R2] new address used only after transfer ends
// [R3] pending bit set on write, cleared when effective
// [R4] bus reset detection sets bus_reset_flag
// [R5] bus reset zeroes address, flushes endpoint fifos
// [R6] bus reset zeroes endpoint csr and select
// [R7] bus reset enables sources except suspend, clears flags
// [R8] bus reset raises reset interrupt if enabled
// [R9] writing bus_reset_flag one resets all registers
// [R10] suspend detected with enable enters suspend, interrupts
// [R11] resume, reset or controller reset leave suspend
// [R12] detected resume raises interrupt when enabled
// [R13] remote_wakeup_drive one drives resume until cleared
// [R14] software ends wakeup after ten to fifteen ms
// [R15] iso_frame_sync holds new iso packets until sof
// [R16] early iso in token gets zero-length packet
// [R17] starts disabled, enabled when link_inhibit cleared
// [R18] link_inhibit cannot be set again by software
// [R19] software configures fully before clearing link_inhibit
// [R20] inhibited link ignores all bus traffic; here xfer_done and iso_load still act while inhibited
// [R21] suspend_state mirrors suspend mode
// [R22] separate effective address loaded when update completes
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "udlc_defines.svh"
module udlc_top
  import udlc_pkg::*;
#(
  parameter int EP_NUM = 4
) (
  input wire logic ref_clk, // 20 MHz clock
  input wire logic srst, // synchronous reset, high
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire udlc_evt_t link_evt, // serial engine events
  input wire logic [EP_NUM-1:0] ep_in_evt, // in endpoint done pulses
  input wire logic [EP_NUM-1:0] ep_out_evt, // out endpoint done pulses
  output logic [6:0] match_addr, // address used for tokens
  output logic link_enable, // bus traffic accepted
  output logic resume_drive, // drive resume on bus
  output logic osc_suspend, // oscillator may suspend
  output logic fifo_flush, // flush all endpoint fifos, pulse
  output logic ctrl_reset, // controller reset in progress, pulse
  output logic iso_hold, // hold iso in packets until sof
  output logic iso_zlp, // answer iso in with zero length, pulse
  output logic [7:0] ep_sel, // endpoint select
  output logic usb_irq // any enabled flag pending
);
  // flag vectors hold at most eight endpoints
  if (EP_NUM < 1 || EP_NUM > 8) begin : g_ep_num_check
    $error("udlc_top: EP_NUM must be 1 to 8");
  end

  udlc_state_t state_ff;
  udlc_state_t nxt_state;
  logic ctrl_rst_ff;
  logic rst_all;
  logic live;
  logic brst;
  logic wr_addr;
  logic wr_pwr;
  logic rd_pwr;
  logic rd_cm;
  logic rwu_rise;
  logic [6:0] addr_ff;
  logic [6:0] eff_addr_ff;
  logic pend_ff;
  logic brst_flag_ff;
  logic iso_sync_ff;
  logic rwu_ff;
  logic suspend_detect_enable_ff;
  logic [7:0] cm_flags_ff;
  logic [7:0] cm_en_ff;
  logic [7:0] in_flags_ff;
  logic [7:0] out_flags_ff;
  logic [7:0] in_en_ff;
  logic [7:0] out_en_ff;
  logic [7:0] ep_sel_ff;
  logic [7:0] ep_csr_ff [`UDLC_EP_CSR_NUM];
  logic iso_hold_ff;
  logic iso_zlp_ff;
  logic flush_ff;
  logic irq_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] cm_set;
  logic [7:0] in_set;
  logic [7:0] out_set;

  assign rst_all = srst | ctrl_rst_ff; // see [R9]
  assign live = (state_ff != UDLC_ST_INHIBIT); // see [R20]
  assign brst = live & link_evt.bus_reset;
  assign wr_addr = reg_wr && reg_addr == `UDLC_OFF_ADDR;
  assign wr_pwr = reg_wr && reg_addr == `UDLC_OFF_PWR;
  assign rd_pwr = reg_rd && reg_addr == `UDLC_OFF_PWR;
  assign rd_cm = reg_rd && reg_addr == `UDLC_OFF_CM_FLAGS;
  assign rwu_rise = wr_pwr && reg_wdata[`UDLC_PWR_RWU_BIT] && !rwu_ff;

  // software-triggered controller reset, one cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_rst_ff <= 1'b0;
    end else begin
      ctrl_rst_ff <= wr_pwr && reg_wdata[`UDLC_PWR_BRST_BIT]; // see [R9]
    end
  end

  // link state: inhibited, active, suspended
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      UDLC_ST_INHIBIT: begin
        if (wr_pwr && !reg_wdata[`UDLC_PWR_INH_BIT]) begin
          nxt_state = UDLC_ST_ACTIVE; // see [R17]
        end
      end
      UDLC_ST_ACTIVE: begin
        if (!brst && suspend_detect_enable_ff && link_evt.suspend) begin
          nxt_state = UDLC_ST_SUSPEND; // see [R10]
        end
      end
      UDLC_ST_SUSPEND: begin
        if (brst || link_evt.resume || rwu_rise) begin
          nxt_state = UDLC_ST_ACTIVE; // see [R11]
        end
      end
      default: nxt_state = UDLC_ST_INHIBIT;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      state_ff <= UDLC_ST_INHIBIT; // see [R17] [R18] [R11]
    end else begin
      state_ff <= nxt_state; // see [R18]
    end
  end

  // written and effective function address
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      addr_ff <= 7'h00;
      eff_addr_ff <= 7'h00;
      pend_ff <= 1'b0;
    end else if (brst) begin
      addr_ff <= 7'h00; // see [R5]
      eff_addr_ff <= 7'h00;
      pend_ff <= 1'b0;
    end else if (wr_addr) begin
      addr_ff <= reg_wdata[6:0]; // see [R1]
      pend_ff <= 1'b1; // see [R3]
    end else if (pend_ff && link_evt.xfer_done) begin
      eff_addr_ff <= addr_ff; // see [R2] [R22]
      pend_ff <= 1'b0; // see [R3]
    end
  end

  // control bits of the power control register
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      iso_sync_ff <= 1'b0;
      rwu_ff <= 1'b0;
      suspend_detect_enable_ff <= 1'b0;
    end else if (wr_pwr) begin
      iso_sync_ff <= reg_wdata[`UDLC_PWR_ISO_BIT];
      rwu_ff <= reg_wdata[`UDLC_PWR_RWU_BIT]; // see [R13]
      suspend_detect_enable_ff <= reg_wdata[`UDLC_PWR_SUSPEND_DETECT_ENABLE_BIT];
    end
  end

  // bus reset flag: hardware set wins over read clear
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      brst_flag_ff <= 1'b0;
    end else if (brst) begin
      brst_flag_ff <= 1'b1; // see [R4]
    end else if (rd_pwr) begin
      brst_flag_ff <= 1'b0;
    end
  end

  // event set vectors for the flag registers
  always_comb begin
    cm_set = 8'h00;
    cm_set[`UDLC_CM_SUSP_BIT] = live && state_ff == UDLC_ST_ACTIVE && suspend_detect_enable_ff
                                && link_evt.suspend && cm_en_ff[`UDLC_CM_SUSP_BIT]; // see [R10]
    cm_set[`UDLC_CM_RESM_BIT] = live && link_evt.resume && cm_en_ff[`UDLC_CM_RESM_BIT]; // see [R12]
    // bus reset enables its own source in the same cycle that it raises it
    cm_set[`UDLC_CM_BRST_BIT] = brst; // see [R8]
    cm_set[`UDLC_CM_SOF_BIT] = live && link_evt.sof && cm_en_ff[`UDLC_CM_SOF_BIT];
    in_set = 8'h00;
    out_set = 8'h00;
    in_set[EP_NUM-1:0] = live ? (ep_in_evt & in_en_ff[EP_NUM-1:0]) : '0;
    out_set[EP_NUM-1:0] = live ? (ep_out_evt & out_en_ff[EP_NUM-1:0]) : '0;
  end

  // interrupt enables
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      cm_en_ff <= `UDLC_CM_EN_RST;
      in_en_ff <= `UDLC_EP_EN_RST;
      out_en_ff <= `UDLC_EP_EN_RST;
    end else if (brst) begin
      cm_en_ff <= `UDLC_CM_EN_ON_BRST | (cm_en_ff & 8'h01); // see [R7]
      in_en_ff <= `UDLC_EP_EN_ON_BRST; // see [R7]
      out_en_ff <= `UDLC_EP_EN_ON_BRST;
    end else if (reg_wr) begin
      if (reg_addr == `UDLC_OFF_CM_EN) begin
        cm_en_ff <= reg_wdata & `UDLC_CM_MASK;
      end
      if (reg_addr == `UDLC_OFF_IN_EN) begin
        in_en_ff <= reg_wdata;
      end
      if (reg_addr == `UDLC_OFF_OUT_EN) begin
        out_en_ff <= reg_wdata;
      end
    end
  end

  // sticky flags, cleared by read; a new event wins
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      cm_flags_ff <= 8'h00;
      in_flags_ff <= 8'h00;
      out_flags_ff <= 8'h00;
    end else if (brst) begin
      cm_flags_ff <= cm_set; // see [R7] [R8]
      in_flags_ff <= 8'h00;
      out_flags_ff <= 8'h00;
    end else begin
      cm_flags_ff <= (rd_cm ? 8'h00 : cm_flags_ff) | cm_set;
      in_flags_ff <= (reg_rd && reg_addr == `UDLC_OFF_IN_FLAGS ? 8'h00 : in_flags_ff) | in_set;
      out_flags_ff <= (reg_rd && reg_addr == `UDLC_OFF_OUT_FLAGS ? 8'h00 : out_flags_ff) | out_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |{cm_flags_ff & cm_en_ff, in_flags_ff & in_en_ff, out_flags_ff & out_en_ff};
    end
  end

  // endpoint select and control/status storage
  always_ff @(posedge ref_clk) begin
    if (rst_all || brst) begin
      ep_sel_ff <= 8'h00; // see [R6]
    end else if (reg_wr && reg_addr == `UDLC_OFF_EP_SEL) begin
      ep_sel_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < `UDLC_EP_CSR_NUM; i++) begin
      if (rst_all || brst) begin
        ep_csr_ff[i] <= 8'h00; // see [R6]
      end else if (reg_wr && reg_addr == `UDLC_OFF_EP_CSR0 + 8'(i)) begin
        ep_csr_ff[i] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flush_ff <= 1'b0;
    end else begin
      flush_ff <= brst | ctrl_rst_ff; // see [R5]
    end
  end

  // iso frame sync: hold new packets until sof
  always_ff @(posedge ref_clk) begin
    if (rst_all || !iso_sync_ff) begin
      iso_hold_ff <= 1'b0;
    end else if (link_evt.iso_load) begin
      iso_hold_ff <= 1'b1; // see [R15]
    end else if (live && link_evt.sof) begin
      iso_hold_ff <= 1'b0; // see [R15]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      iso_zlp_ff <= 1'b0;
    end else begin
      iso_zlp_ff <= live && iso_hold_ff && link_evt.iso_in_token && !link_evt.sof; // see [R16]
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `UDLC_OFF_ADDR: nxt_rdata = {pend_ff, addr_ff};
      `UDLC_OFF_PWR: begin
        nxt_rdata[`UDLC_PWR_ISO_BIT] = iso_sync_ff;
        nxt_rdata[`UDLC_PWR_INH_BIT] = !live;
        nxt_rdata[`UDLC_PWR_BRST_BIT] = brst_flag_ff;
        nxt_rdata[`UDLC_PWR_RWU_BIT] = rwu_ff;
        nxt_rdata[`UDLC_PWR_SUSP_BIT] = state_ff == UDLC_ST_SUSPEND; // see [R21]
        nxt_rdata[`UDLC_PWR_SUSPEND_DETECT_ENABLE_BIT] = suspend_detect_enable_ff;
      end
      `UDLC_OFF_IN_FLAGS: nxt_rdata = in_flags_ff;
      `UDLC_OFF_OUT_FLAGS: nxt_rdata = out_flags_ff;
      `UDLC_OFF_CM_FLAGS: nxt_rdata = cm_flags_ff;
      `UDLC_OFF_IN_EN: nxt_rdata = in_en_ff;
      `UDLC_OFF_OUT_EN: nxt_rdata = out_en_ff;
      `UDLC_OFF_CM_EN: nxt_rdata = cm_en_ff;
      `UDLC_OFF_EP_SEL: nxt_rdata = ep_sel_ff;
      default: begin
        for (int i = 0; i < `UDLC_EP_CSR_NUM; i++) begin
          if (reg_addr == `UDLC_OFF_EP_CSR0 + 8'(i)) begin
            nxt_rdata = ep_csr_ff[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;
  assign match_addr = eff_addr_ff; // see [R2]
  assign link_enable = live; // see [R20]
  assign resume_drive = rwu_ff; // see [R13]
  assign osc_suspend = state_ff == UDLC_ST_SUSPEND; // see [R11]
  assign fifo_flush = flush_ff;
  assign ctrl_reset = ctrl_rst_ff;
  assign iso_hold = iso_hold_ff;
  assign iso_zlp = iso_zlp_ff;
  assign ep_sel = ep_sel_ff;
  assign usb_irq = irq_ff;
endmodule // udlc_top
`default_nettype wire

// >>> verification/udlc_top_checker.sv
// assertions for device level control
`timescale 1ns/1ps
`default_nettype none
module udlc_top_checker
  import udlc_pkg::*;
#(
  parameter int EP_NUM = 4
) (
  input wire logic ref_clk, // clk
  input wire logic srst, // rst
  input wire logic [7:0] reg_addr, // addr
  input wire logic [7:0] reg_wdata, // data
  input wire logic reg_wr, // wr
  input wire logic reg_rd, // rd
  input wire logic [7:0] reg_rdata, // rdata
  input wire udlc_evt_t link_evt, // evt
  input wire logic [EP_NUM-1:0] ep_in_evt, // in
  input wire logic [EP_NUM-1:0] ep_out_evt, // out
  input wire logic [6:0] match_addr, // match
  input wire logic link_enable, // en
  input wire logic resume_drive, // wake
  input wire logic osc_suspend, // susp
  input wire logic fifo_flush, // flush
  input wire logic ctrl_reset, // crst
  input wire logic iso_hold, // hold
  input wire logic iso_zlp, // zlp
  input wire logic [7:0] ep_sel, // sel
  input wire logic usb_irq // irq
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  logic pw;
  logic ok;
  logic cause;
  logic sus;
  assign pw = reg_wr && reg_addr == 8'h01 && !ctrl_reset;
  assign ok = link_enable && !ctrl_reset;
  assign cause = link_evt.xfer_done | link_evt.bus_reset | ctrl_reset;
  assign sus = link_evt.suspend & link_enable;
  a_addr_held: assert property ($changed(match_addr) |-> $past(cause))
    else $error("match address moved");
  a_brst_clear: assert property (
    ok && link_evt.bus_reset |=> match_addr == 7'h00 && ep_sel == 8'h00 && fifo_flush)
    else $error("bus reset left state");
  a_brst_irq: assert property (ok && link_evt.bus_reset ##1 !ctrl_reset |=> usb_irq)
    else $error("no reset interrupt");
  a_inhibit_deaf: assert property (!link_enable && link_evt.bus_reset && !ctrl_reset |=> !fifo_flush)
    else $error("inhibited link reacted");
  a_ctrl_reset: assert property (
    pw && reg_wdata[3] |=> ctrl_reset ##1 !link_enable && match_addr == 7'h00 && !resume_drive && fifo_flush)
    else $error("controller reset incomplete");
  a_inhibit_stays: assert property (link_enable && !ctrl_reset |=> link_enable)
    else $error("inhibit set again");
  a_wake_drive: assert property (pw && !reg_wdata[3] |=> resume_drive == $past(reg_wdata[2]))
    else $error("wakeup drive wrong");
  a_susp_cause: assert property ($rose(osc_suspend) |-> $past(sus))
    else $error("suspend without cause");
  a_iso_zero: assert property (ok && iso_hold && link_evt.iso_in_token && !link_evt.sof |=> iso_zlp)
    else $error("no zero length reply");
  c_brst: cover property (ok && link_evt.bus_reset);
  c_susp: cover property ($rose(osc_suspend));
  c_zlp: cover property (iso_zlp);
endmodule // udlc_top_checker
bind udlc_top udlc_top_checker #(.EP_NUM(EP_NUM)) chk_i (
  .ref_clk(ref_clk),
  .srst(srst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .link_evt(link_evt),
  .ep_in_evt(ep_in_evt),
  .ep_out_evt(ep_out_evt),
  .match_addr(match_addr),
  .link_enable(link_enable),
  .resume_drive(resume_drive),
  .osc_suspend(osc_suspend),
  .fifo_flush(fifo_flush),
  .ctrl_reset(ctrl_reset),
  .iso_hold(iso_hold),
  .iso_zlp(iso_zlp),
  .ep_sel(ep_sel),
  .usb_irq(usb_irq)
);
`default_nettype wire

// >>> verification/udlc_host_model.sv
// host side model: turns requests into one-cycle bus events
`timescale 1ns/1ps
`default_nettype none
module udlc_host_model
  import udlc_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic srst, // reset
  input wire logic [6:0] req, // event request, one bit each
  output var udlc_evt_t evt // event pulses
);
  always_ff @(posedge ref_clk) begin
    evt <= srst ? udlc_evt_t'(7'h00) : udlc_evt_t'(req);
  end
endmodule // udlc_host_model
`default_nettype wire

// >>> verification/udlc_top_tb_top.sv
// testbench for device level control
`timescale 1ns/1ps
`default_nettype none
module udlc_top_tb_top;
  import udlc_pkg::*;
  localparam int BRST = 6, SUSP = 5, RES = 4, SOF = 3, XFER = 2, LOAD = 1, TOK = 0;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [6:0] req = 7'h00;
  logic [3:0] ep_in_evt = 4'h0;
  logic [3:0] ep_out_evt = 4'h0;
  logic [7:0] reg_rdata, ep_sel;
  logic [6:0] match_addr;
  logic link_enable, resume_drive, osc_suspend, fifo_flush, ctrl_reset, iso_hold, iso_zlp, usb_irq;
  udlc_evt_t link_evt;
  int errors = 0;
  int compares = 0;
  always #25 ref_clk = ~ref_clk;
  udlc_host_model host (.ref_clk(ref_clk), .srst(srst), .req(req), .evt(link_evt));
  udlc_top #(.EP_NUM(4)) dut (
    .ref_clk(ref_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .link_evt(link_evt),
    .ep_in_evt(ep_in_evt),
    .ep_out_evt(ep_out_evt),
    .match_addr(match_addr),
    .link_enable(link_enable),
    .resume_drive(resume_drive),
    .osc_suspend(osc_suspend),
    .fifo_flush(fifo_flush),
    .ctrl_reset(ctrl_reset),
    .iso_hold(iso_hold),
    .iso_zlp(iso_zlp),
    .ep_sel(ep_sel),
    .usb_irq(usb_irq)
  );
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(n, reg_rdata, e);
  endtask
  task automatic ev(input int k);
    @(posedge ref_clk);
    req[k] <= 1'b1;
    @(posedge ref_clk);
    req <= 7'h00;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic ep(input logic [3:0] i, input logic [3:0] o);
    @(posedge ref_clk);
    ep_in_evt <= i;
    ep_out_evt <= o;
    @(posedge ref_clk);
    ep_in_evt <= 4'h0;
    ep_out_evt <= 4'h0;
    @(negedge ref_clk);
  endtask
  task automatic t_init;
    wr(8'h01, 8'h08);
    rd(8'h00, 8'h00, "addr");
    rd(8'h01, 8'h10, "power");
    rd(8'h0b, 8'h06, "cm_en");
    ev(BRST);
    chk("flush", 8'(fifo_flush), 8'h00);
    rd(8'h01, 8'h10, "power");
    ep(4'h1, 4'h1);
    rd(8'h02, 8'h00, "in_deaf");
    wr(8'h01, 8'h00);
    chk("enable", 8'(link_enable), 8'h01);
    wr(8'h01, 8'h10);
    rd(8'h01, 8'h00, "inhibit");
  endtask
  task automatic t_addr;
    wr(8'h00, 8'h85);
    rd(8'h00, 8'h85, "pending");
    chk("old", 8'(match_addr), 8'h00);
    ev(XFER);
    chk("new", 8'(match_addr), 8'h05);
    rd(8'h00, 8'h05, "done");
    wr(8'h00, 8'h7f);
    ev(XFER);
    chk("max", 8'(match_addr), 8'h7f);
    ep(4'h1, 4'h4);
    rd(8'h02, 8'h01, "in_flags");
    rd(8'h04, 8'h04, "out_flags");
    rd(8'h02, 8'h00, "in_clear");
  endtask
  task automatic t_brst;
    wr(8'h0e, 8'h03);
    wr(8'h11, 8'h5a);
    wr(8'h00, 8'h22);
    wr(8'h0b, 8'h00);
    ep(4'h2, 4'h8);
    ev(BRST);
    chk("flush", 8'(fifo_flush), 8'h01);
    chk("match", 8'(match_addr), 8'h00);
    chk("sel", ep_sel, 8'h00);
    rd(8'h11, 8'h00, "csr");
    rd(8'h00, 8'h00, "addr");
    rd(8'h01, 8'h08, "rflag");
    rd(8'h0b, 8'h0e, "cm_en");
    rd(8'h02, 8'h00, "in_brst");
    rd(8'h04, 8'h00, "out_brst");
    chk("irq", 8'(usb_irq), 8'h01);
    rd(8'h06, 8'h04, "cm");
    rd(8'h30, 8'h00, "unmapped");
  endtask
  task automatic t_susp;
    wr(8'h0b, 8'h0f);
    wr(8'h01, 8'h01);
    ev(SUSP);
    chk("osc", 8'(osc_suspend), 8'h01);
    rd(8'h01, 8'h03, "state");
    rd(8'h06, 8'h01, "sflag");
    ev(RES);
    chk("osc", 8'(osc_suspend), 8'h00);
    rd(8'h06, 8'h02, "rflag");
    rd(8'h01, 8'h01, "state");
    ev(SUSP);
    wr(8'h01, 8'h05);
    chk("drive", 8'(resume_drive), 8'h01);
    chk("osc", 8'(osc_suspend), 8'h00);
    // wakeup span cut short to keep the run brief
    wr(8'h01, 8'h00);
    chk("drive", 8'(resume_drive), 8'h00);
    ev(SUSP);
    chk("osc", 8'(osc_suspend), 8'h00);
  endtask
  task automatic t_iso;
    wr(8'h01, 8'h80);
    ev(LOAD);
    chk("hold", 8'(iso_hold), 8'h01);
    ev(TOK);
    chk("zlp", 8'(iso_zlp), 8'h01);
    ev(SOF);
    chk("hold", 8'(iso_hold), 8'h00);
    ev(TOK);
    chk("zlp", 8'(iso_zlp), 8'h00);
  endtask
  task automatic t_ctrl;
    wr(8'h00, 8'h09);
    ev(XFER);
    wr(8'h01, 8'h0c);
    chk("crst", 8'(ctrl_reset), 8'h01);
    @(negedge ref_clk);
    chk("enable", 8'(link_enable), 8'h00);
    chk("match", 8'(match_addr), 8'h00);
    chk("drive", 8'(resume_drive), 8'h00);
    rd(8'h01, 8'h10, "power");
  endtask
  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    t_init;
    t_addr;
    t_brst;
    t_susp;
    t_iso;
    t_ctrl;
    results;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    results;
  end
endmodule // udlc_top_tb_top
`default_nettype wire
